// ==== pkg/dpss_pkg.sv ====
// Purpose: Shared constants and types of the dual port synchronous memory.
// Assumes: Core clock clk_i at 25 MHz; device clock k_i arrives as a pin.
// Notes: Word layout is parity in bit 8, data in bits 7..0.
package dpss_pkg;

    localparam int ADDR_W = 17;
    localparam int WORD_W = 9;
    localparam int PARITY_BIT = 8;
    localparam int MEM_WORDS = 131072;
    localparam int FIFO_DEPTH = 8;
    // FIFO word: {to_proc, to_sys, word}
    localparam int FIFO_W = WORD_W + 2;
    localparam int FIFO_TO_PROC = WORD_W + 1;
    localparam int FIFO_TO_SYS = WORD_W;

    // Pin sample vector layout
    localparam int PIN_W = 1 + ADDR_W + 3 + 2 * WORD_W;
    localparam int PIN_K = 0;
    localparam int PIN_ADDR = 1;
    localparam int PIN_WE = PIN_ADDR + ADDR_W;
    localparam int PIN_PIE = PIN_WE + 1;
    localparam int PIN_SIE = PIN_PIE + 1;
    localparam int PIN_PD = PIN_SIE + 1;
    localparam int PIN_SD = PIN_PD + WORD_W;

    // Device clock period limits kept by the controlling parties
    localparam int CLK_HZ = 25_000_000;
    localparam int K_PERIOD_FAST_NS = 16;
    localparam int K_PERIOD_SLOW_NS = 20;
    localparam int K_PERIOD_FAST_CYC = (K_PERIOD_FAST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int K_PERIOD_SLOW_CYC = (K_PERIOD_SLOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        DPSS_CYC_NONE,
        DPSS_CYC_READ,
        DPSS_CYC_WRITE,
        DPSS_CYC_STREAM
    } dpss_cyc_t;

endpackage : dpss_pkg

// ==== rtl/dpss_parts.sv ====
// Purpose: Storage array and word FIFO of the dual port memory.
// Assumes: Single clock; array has no reset, as a real memory has none.
// Notes: Array read data comes out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module dpss_mem #(
    parameter int AW = 17,
    parameter int DW = 9,
    parameter int WORDS = 131072
) (
    // Clock
    input wire logic clk_i,
    // Access
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] store [WORDS];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            store[addr_i] <= wdata_i;
        end
        rdata_o <= store[addr_i];
    end
endmodule : dpss_mem

////////////////////////////////////////////////////////////////////////////////

module dpss_fifo #(
    parameter int W = 11,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int PW = $clog2(D);
    logic [W-1:0] slot [D];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    always_comb begin
        in_ready_o = (count != (PW+1)'(D));
        out_valid_o = (count != '0);
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = (PW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (PW+1)'(count - 1'b1);
        end
        out_data_o = slot[rd_ptr];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            slot[wr_ptr] <= in_data_i;
        end
    end
endmodule : dpss_fifo

`default_nettype wire

// ==== rtl/dpss_top.sv ====
// Purpose: Dual port synchronous 128K x 9 memory with port to port streaming.
// Assumes: Device clock k_i and all pins but the two output enables are sampled by clk_i through two flops.
// Notes: Output enables act without the clock, as on the real pins.
`timescale 1ns/1ps
`default_nettype none

module dpss_top
    import dpss_pkg::*;
(
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Device clock and control pins
    input wire logic k_i,
    input wire logic [dpss_pkg::ADDR_W-1:0] addr_i,
    input wire logic write_n_i,
    input wire logic proc_in_enable_n_i,
    input wire logic sys_in_enable_n_i,
    input wire logic proc_out_enable_n_i,
    input wire logic sys_out_enable_n_i,
    // Processor data port
    input wire logic [7:0] proc_data_bus_i,
    input wire logic proc_parity_bit_i,
    output logic [7:0] proc_data_bus_o,
    output logic proc_parity_bit_o,
    output logic proc_data_oe_o,
    // System data port
    input wire logic [7:0] sys_data_bus_i,
    input wire logic sys_parity_bit_i,
    output logic [7:0] sys_data_bus_o,
    output logic sys_parity_bit_o,
    output logic sys_data_oe_o,
    // Back-pressure of the latch FIFO
    output logic bus_ready_o
);
    import dpss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [PIN_W-1:0] pin_raw, pin_meta, pin_sync;
    logic k_prev;

    assign pin_raw = {sys_parity_bit_i, sys_data_bus_i, proc_parity_bit_i, proc_data_bus_i,
                      sys_in_enable_n_i, proc_in_enable_n_i, write_n_i, addr_i, k_i};

    // Not reset: the flops track the pins during reset, so no false k edge follows it
    always_ff @(posedge clk_i) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
        k_prev <= pin_sync[PIN_K];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle decode
    logic k_high, k_rise, k_fall;
    logic we_low, pie_low, sie_low;
    logic [WORD_W-1:0] proc_word, sys_word, in_word;
    dpss_cyc_t cyc;

    always_comb begin
        k_high = pin_sync[PIN_K];
        k_rise = k_high && !k_prev;
        k_fall = !k_high && k_prev;
        we_low = !pin_sync[PIN_WE];
        pie_low = !pin_sync[PIN_PIE];
        sie_low = !pin_sync[PIN_SIE];
        proc_word = pin_sync[PIN_PD +: WORD_W];
        sys_word = pin_sync[PIN_SD +: WORD_W];
        in_word = pie_low ? proc_word : sys_word;
        cyc = DPSS_CYC_NONE;
        // A k rise during reset must not touch the array
        if (k_rise && !rst_i) begin
            if (pie_low && sie_low) begin
                cyc = DPSS_CYC_NONE;
            end else if (pie_low || sie_low) begin
                cyc = we_low ? DPSS_CYC_WRITE : DPSS_CYC_STREAM;
            end else if (!we_low) begin
                cyc = DPSS_CYC_READ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampled control state
    logic [ADDR_W-1:0] addr_q, next_addr_q;
    logic pie_q, sie_q, float_q, rd_pend;
    logic next_pie_q, next_sie_q, next_float_q, next_rd_pend;

    always_comb begin
        next_addr_q = k_fall ? pin_sync[PIN_ADDR +: ADDR_W] : addr_q;
        next_pie_q = pie_q;
        next_sie_q = sie_q;
        next_float_q = float_q;
        next_rd_pend = (cyc == DPSS_CYC_READ);
        if (k_rise) begin
            next_pie_q = pie_low;
            next_sie_q = sie_low;
            // Both ports float after a write with no port selected, or both selected
            next_float_q = (we_low && !pie_low && !sie_low) || (pie_low && sie_low);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= '0;
            pie_q <= 1'b0;
            sie_q <= 1'b0;
            float_q <= 1'b1;
            rd_pend <= 1'b0;
        end else begin
            addr_q <= next_addr_q;
            pie_q <= next_pie_q;
            sie_q <= next_sie_q;
            float_q <= next_float_q;
            rd_pend <= next_rd_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array and latch FIFO
    logic [WORD_W-1:0] mem_rdata;
    logic fifo_in_valid, fifo_out_valid, fifo_out_ready;
    logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;

    dpss_mem #(
        .AW(ADDR_W),
        .DW(WORD_W),
        .WORDS(MEM_WORDS)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(cyc == DPSS_CYC_WRITE),
        .addr_i(addr_q),
        .wdata_i(in_word),
        .rdata_o(mem_rdata)
    );

    always_comb begin
        fifo_in_valid = rd_pend || (cyc == DPSS_CYC_WRITE) || (cyc == DPSS_CYC_STREAM);
        if (rd_pend) begin
            fifo_in_data = {1'b1, 1'b1, mem_rdata};
        end else begin
            // Input word heads for the opposite port's latch
            fifo_in_data = {sie_low, pie_low, in_word};
        end
        // Latches only take words while the device clock is high
        fifo_out_ready = k_high;
    end

    // Words arriving while full are dropped; bus_ready_o warns the controllers
    dpss_fifo #(
        .W(FIFO_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(bus_ready_o),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output latches and drivers
    logic [WORD_W-1:0] proc_latch, sys_latch, next_proc_latch, next_sys_latch;
    logic pop;

    always_comb begin
        pop = fifo_out_valid && fifo_out_ready;
        next_proc_latch = proc_latch;
        next_sys_latch = sys_latch;
        if (pop && fifo_out_data[FIFO_TO_PROC]) begin
            next_proc_latch = fifo_out_data[WORD_W-1:0];
        end
        if (pop && fifo_out_data[FIFO_TO_SYS]) begin
            next_sys_latch = fifo_out_data[WORD_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            proc_latch <= '0;
            sys_latch <= '0;
        end else begin
            proc_latch <= next_proc_latch;
            sys_latch <= next_sys_latch;
        end
    end

    // Output enables bypass the synchroniser so the pins float without the clock
    always_comb begin
        proc_data_oe_o = !proc_out_enable_n_i && !pie_q && !float_q;
        sys_data_oe_o = !sys_out_enable_n_i && !sie_q && !float_q;
        proc_data_bus_o = proc_latch[7:0];
        proc_parity_bit_o = proc_latch[PARITY_BIT];
        sys_data_bus_o = sys_latch[7:0];
        sys_parity_bit_o = sys_latch[PARITY_BIT];
    end

endmodule : dpss_top

`default_nettype wire

// ==== testbench/dpss_far_model.sv ====
// Purpose: Wire level of one data port with its bus controller.
// Assumes: Controller drives only while its input enable is low.
// Notes: A released wire toggles so a stale value never reads back.
`timescale 1ns/1ps
`default_nettype none
module dpss_far_model (
    // Clock
    input wire logic clk_i,
    // Controller side
    input wire logic drv_i,
    input wire logic [8:0] val_i,
    // Device side and resolved wire
    input wire logic oe_i,
    input wire logic [8:0] dev_i,
    output logic [8:0] wire_o
);
    logic [8:0] last = 9'h000;
    // Device floats a receiving port, so no fight here
    always_comb wire_o = oe_i ? dev_i : (drv_i ? val_i : ~last);
    always_ff @(posedge clk_i) last <= wire_o;
endmodule : dpss_far_model
`default_nettype wire

// ==== testbench/dpss_props.sv ====
// Purpose: Port checks of the dual port memory.
// Assumes: k_i levels held three or more core clocks.
// Notes: Five clocks after a pin rise the latches have settled.
`timescale 1ns/1ps
`default_nettype none
module dpss_props (
    // Clock and pins
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic k_i,
    input wire logic write_n_i,
    input wire logic proc_in_enable_n_i,
    input wire logic sys_in_enable_n_i,
    input wire logic proc_out_enable_n_i,
    input wire logic sys_out_enable_n_i,
    input wire logic [7:0] proc_data_bus_i,
    input wire logic proc_parity_bit_i,
    input wire logic [7:0] sys_data_bus_i,
    input wire logic sys_parity_bit_i,
    // Outputs
    input wire logic [7:0] proc_data_bus_o,
    input wire logic proc_parity_bit_o,
    input wire logic proc_data_oe_o,
    input wire logic [7:0] sys_data_bus_o,
    input wire logic sys_parity_bit_o,
    input wire logic sys_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_prx;
        $rose(k_i) && !proc_in_enable_n_i && sys_in_enable_n_i;
    endsequence
    sequence s_srx;
        $rose(k_i) && !sys_in_enable_n_i && proc_in_enable_n_i;
    endsequence
    sequence s_read;
        $rose(k_i) && write_n_i && proc_in_enable_n_i && sys_in_enable_n_i;
    endsequence
    property p_oe_p;
        proc_out_enable_n_i |-> !proc_data_oe_o;
    endproperty
    a_oe_p: assert property (p_oe_p) else $error("proc port drives with oe high");
    property p_oe_s;
        sys_out_enable_n_i |-> !sys_data_oe_o;
    endproperty
    a_oe_s: assert property (p_oe_s) else $error("sys port drives with oe high");
    // Two sync flops plus the latch flop: a change trails its k sample by three clocks
    property p_hold_p;
        $changed(proc_data_bus_o) |-> $past(k_i, 3);
    endproperty
    a_hold_p: assert property (p_hold_p) else $error("proc latch moved in low k");
    property p_hold_s;
        $changed(sys_data_bus_o) |-> $past(k_i, 3);
    endproperty
    a_hold_s: assert property (p_hold_s) else $error("sys latch moved in low k");
    property p_rx;
        $rose(k_i) && !proc_in_enable_n_i |-> ##5 !proc_data_oe_o;
    endproperty
    a_rx: assert property (p_rx) else $error("receiving proc port drives");
    property p_nop;
        $rose(k_i) && !write_n_i && proc_in_enable_n_i && sys_in_enable_n_i
            |-> ##5 !proc_data_oe_o && !sys_data_oe_o;
    endproperty
    a_nop: assert property (p_nop) else $error("port drives in idle write");
    property p_str_ps;
        s_prx |-> ##5 {sys_parity_bit_o, sys_data_bus_o} ==
            $past({proc_parity_bit_i, proc_data_bus_i}, 5);
    endproperty
    a_str_ps: assert property (p_str_ps) else $error("proc word not on sys");
    property p_str_sp;
        s_srx |-> ##5 {proc_parity_bit_o, proc_data_bus_o} ==
            $past({sys_parity_bit_i, sys_data_bus_i}, 5);
    endproperty
    a_str_sp: assert property (p_str_sp) else $error("sys word not on proc");
    property p_rd;
        s_read ##5 !proc_out_enable_n_i |-> proc_data_oe_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read not driven on proc");
endmodule : dpss_props
bind dpss_top dpss_props i_dpss_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .k_i(k_i),
    .write_n_i(write_n_i),
    .proc_in_enable_n_i(proc_in_enable_n_i),
    .sys_in_enable_n_i(sys_in_enable_n_i),
    .proc_out_enable_n_i(proc_out_enable_n_i),
    .sys_out_enable_n_i(sys_out_enable_n_i),
    .proc_data_bus_i(proc_data_bus_i),
    .proc_parity_bit_i(proc_parity_bit_i),
    .sys_data_bus_i(sys_data_bus_i),
    .sys_parity_bit_i(sys_parity_bit_i),
    .proc_data_bus_o(proc_data_bus_o),
    .proc_parity_bit_o(proc_parity_bit_o),
    .proc_data_oe_o(proc_data_oe_o),
    .sys_data_bus_o(sys_data_bus_o),
    .sys_parity_bit_o(sys_parity_bit_o),
    .sys_data_oe_o(sys_data_oe_o)
);
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Scenario bench of the dual port memory.
// Assumes: k_i period of thirteen core clocks.
// Notes: Ports observed at the resolved wire level.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, k = 1'b1, wn = 1'b1, proc_in_enable_n = 1'b1, sys_in_enable_n = 1'b1;
    logic proc_out_enable_n = 1'b1, sys_out_enable_n = 1'b1, pdrv = 1'b0, sdrv = 1'b0;
    logic [16:0] addr = 17'h00000;
    logic [8:0] val = 9'h000;
    logic [8:0] pw, sw, pd, sd;
    logic poe_o, soe_o, rdy;
    int err_count = 0, checks = 0;
    always #20 clk_i = ~clk_i;
    dpss_far_model i_far_p (.clk_i(clk_i), .drv_i(pdrv), .val_i(val), .oe_i(poe_o),
        .dev_i(pd), .wire_o(pw));
    dpss_far_model i_far_s (.clk_i(clk_i), .drv_i(sdrv), .val_i(val), .oe_i(soe_o),
        .dev_i(sd), .wire_o(sw));
    dpss_top i_dpss_top (.clk_i(clk_i), .rst_i(rst_i), .k_i(k), .addr_i(addr),
        .write_n_i(wn), .proc_in_enable_n_i(proc_in_enable_n), .sys_in_enable_n_i(sys_in_enable_n),
        .proc_out_enable_n_i(proc_out_enable_n), .sys_out_enable_n_i(sys_out_enable_n),
        .proc_data_bus_i(pw[7:0]), .proc_parity_bit_i(pw[8]),
        .proc_data_bus_o(pd[7:0]), .proc_parity_bit_o(pd[8]), .proc_data_oe_o(poe_o),
        .sys_data_bus_i(sw[7:0]), .sys_parity_bit_i(sw[8]),
        .sys_data_bus_o(sd[7:0]), .sys_parity_bit_o(sd[8]), .sys_data_oe_o(soe_o),
        .bus_ready_o(rdy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One k period; a2 replaces the address once k is low
    task automatic kcyc(input logic [16:0] a, a2, input logic w, pi, si, input logic [8:0] d);
        @(negedge clk_i) addr = a;
        repeat (2) @(negedge clk_i);
        k = 1'b0;
        wn = w;
        proc_in_enable_n = pi;
        sys_in_enable_n = si;
        pdrv = !pi;
        sdrv = !si;
        val = d;
        // Address held one clock past the fall to respect its hold time
        @(negedge clk_i) addr = a2;
        repeat (3) @(negedge clk_i);
        k = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : kcyc
    task automatic set_oe(input logic p, s);
        proc_out_enable_n = p;
        sys_out_enable_n = s;
    endtask : set_oe
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write;
        set_oe(1'b0, 1'b0);
        kcyc(17'h00005, 17'h00005, 1'b0, 1'b0, 1'b1, 9'h1a5);
        chk(sw, 9'h1a5);
        chk(9'(soe_o), 9'h001);
        chk(9'(poe_o), 9'h000);
        // System output stays off while the controller drives that port
        set_oe(1'b0, 1'b1);
        kcyc(17'h1ffff, 17'h1ffff, 1'b0, 1'b1, 1'b0, 9'h0ff);
        chk(pw, 9'h0ff);
        sys_out_enable_n = 1'b0;
        #1 chk(9'(soe_o), 9'h000);
        set_oe(1'b0, 1'b0);
        kcyc(17'h1ffff, 17'h1ffff, 1'b0, 1'b1, 1'b0, 9'h0ff);
        chk(pw, 9'h0ff);
        $display("test write done");
    endtask : t_write
    task automatic t_read;
        set_oe(1'b0, 1'b1);
        kcyc(17'h00005, 17'h1ffff, 1'b1, 1'b1, 1'b1, 9'h000);
        chk(pw, 9'h1a5);
        chk(9'(soe_o), 9'h000);
        sys_out_enable_n = 1'b0;
        #1 chk(sw, 9'h1a5);
        @(negedge clk_i) proc_out_enable_n = 1'b1;
        #1 chk(9'(poe_o), 9'h000);
        @(negedge clk_i) k = 1'b0;
        repeat (5) @(negedge clk_i);
        chk(sw, 9'h1a5);
        set_oe(1'b1, 1'b0);
        kcyc(17'h1ffff, 17'h1ffff, 1'b1, 1'b1, 1'b1, 9'h000);
        chk(sw, 9'h0ff);
        $display("test read done");
    endtask : t_read
    task automatic t_stream;
        set_oe(1'b1, 1'b0);
        kcyc(17'h00005, 17'h00005, 1'b1, 1'b0, 1'b1, 9'h033);
        chk(sw, 9'h033);
        kcyc(17'h00005, 17'h00005, 1'b1, 1'b1, 1'b1, 9'h000);
        chk(sw, 9'h1a5);
        set_oe(1'b0, 1'b1);
        kcyc(17'h00005, 17'h00005, 1'b1, 1'b1, 1'b0, 9'h0c3);
        chk(pw, 9'h0c3);
        chk(9'(rdy), 9'h001);
        $display("test stream done");
    endtask : t_stream
    task automatic t_nop;
        set_oe(1'b0, 1'b0);
        kcyc(17'h00005, 17'h00005, 1'b0, 1'b1, 1'b1, 9'h111);
        chk({7'h00, poe_o, soe_o}, 9'h000);
        kcyc(17'h00005, 17'h00005, 1'b0, 1'b0, 1'b0, 9'h0aa);
        chk({7'h00, poe_o, soe_o}, 9'h000);
        kcyc(17'h00005, 17'h00005, 1'b1, 1'b1, 1'b1, 9'h000);
        chk(pw, 9'h1a5);
        $display("test nop done");
    endtask : t_nop
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        t_write();
        t_read();
        t_stream();
        t_nop();
        complete_run();
    end
    // About 20 k periods of 13 clocks would be ample
    initial begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
